// [dp_ctrl.sv]
// Data path control block with AHB-Lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dp_ctrl (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Module level conditions
   input  wire logic        module_ready_term,
   input  wire logic        low_power_condition,
   input  wire logic        reset_condition,
   // Lane electronics
   input  wire logic [7:0]  lane_ready,
   input  wire logic [7:0]  lane_powered,
   input  wire logic [7:0]  tx_los,
   output logic      [7:0]  lane_power_up,
   output logic      [7:0]  lane_init_start,
   output logic      [7:0]  tx_quiet
);
   localparam int L = dp_pkg::LANES;
   localparam int P = dp_pkg::PATHS;

   // Pin inputs
   logic [26:0] pins_s;
   logic        ready_s;
   logic        lowpwr_s;
   logic        reset_s;
   logic [7:0]  lane_ready_s;
   logic [7:0]  lane_powered_s;
   logic [7:0]  tx_los_s;

   sync_2ff #(.W(27)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({module_ready_term, low_power_condition, reset_condition,
                 lane_ready, lane_powered, tx_los}),
      .q       (pins_s)
   );
   assign {ready_s, lowpwr_s, reset_s, lane_ready_s, lane_powered_s, tx_los_s} = pins_s;

   // Software state
   logic [7:0]  deinit_req_q, deinit_req_d;
   logic [7:0]  apply_q, apply_d;
   logic [7:0]  tx_dis_q, tx_dis_d;
   logic [7:0]  squelch_q, squelch_d;
   logic [23:0] lane_path_q, lane_path_d;
   logic [3:0]  init_dur_q, init_dur_d;
   // Bus state
   logic        wr_pend_q, wr_pend_d;
   logic [7:0]  wr_addr_q, wr_addr_d;
   logic [31:0] hrdata_d;
   logic        rd_chg, rd_los;
   // Lane state
   logic [31:0] report_q, report_d;
   logic [31:0] pend_q, pend_d;
   logic [7:0]  changed_q, changed_d;
   logic [7:0]  los_flag_q, los_flag_d;
   logic [7:0]  power_d, init_d, quiet_d;

   dp_pkg::path_cond_t cond [P];
   dp_pkg::dp_state_t  st   [P];
   dp_pkg::dp_state_t  pv   [P];
   // Cycles spent in init, saturating at the settle count
   logic [2:0]         init_age_q [P];
   logic [2:0]         init_age_d [P];

   function automatic logic [2:0] path_of(input logic [23:0] map, input int l);
      return map[3*l +: 3];
   endfunction : path_of

   // OR of lane bits that belong to path p
   function automatic logic path_any(input logic [7:0] v, input logic [23:0] map,
                                     input int p);
      logic r;
      r = 1'b0;
      for (int l = 0; l < L; l++) begin
         if (path_of(map, l) == p[2:0]) r = r | v[l];
      end
      return r;
   endfunction : path_any

   // AND of lane bits that belong to path p
   function automatic logic path_all(input logic [7:0] v, input logic [23:0] map,
                                     input int p);
      logic r;
      r = 1'b1;
      for (int l = 0; l < L; l++) begin
         if (path_of(map, l) == p[2:0]) r = r & v[l];
      end
      return r;
   endfunction : path_all

   // Path conditions from lane bits; one write may move many paths
   always_comb begin
      for (int p = 0; p < P; p++) begin
         cond[p].reset      = reset_s;
         cond[p].deinit     = !ready_s | lowpwr_s
                              | path_any(deinit_req_q, lane_path_q, p);
         cond[p].redeinit   = cond[p].deinit
                              | path_any(apply_q, lane_path_q, p);
         cond[p].deactivate = cond[p].redeinit
                              | path_any(tx_dis_q, lane_path_q, p)
                              | path_any(squelch_q, lane_path_q, p);
         // Lane status counts only once the start pulse has gone out and back
         cond[p].init_done  = (st[p] == dp_pkg::S_INIT)
                              & (init_age_q[p] == dp_pkg::INIT_SETTLE)
                              & path_all(lane_ready_s & lane_powered_s,
                                         lane_path_q, p);
      end
   end

   for (genvar p = 0; p < P; p++) begin : g_path
      dp_fsm u_fsm (
         .hclk    (hclk),
         .hresetn (hresetn),
         .cond    (cond[p]),
         .state_q (st[p]),
         .prev_q  (pv[p])
      );
   end

   // Without this wait a stale ready from an earlier init would end a new one at once
   always_comb begin
      for (int p = 0; p < P; p++) begin
         init_age_d[p] = 3'h0;
         if (st[p] == dp_pkg::S_INIT) begin
            init_age_d[p] = init_age_q[p];
            if (init_age_q[p] != dp_pkg::INIT_SETTLE) begin
               init_age_d[p] = init_age_q[p] + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_age_q <= '{default: 3'h0};
      end else begin
         init_age_q <= init_age_d;
      end
   end

   // Bus slave: zero wait, read data registered at address phase
   always_comb begin
      logic take;
      take         = hsel & htrans[1] & hready;
      wr_pend_d    = take & hwrite;
      wr_addr_d    = take ? haddr[7:0] : wr_addr_q;
      rd_chg       = take & !hwrite & (haddr[7:0] == dp_pkg::OFS_CHANGED);
      rd_los       = take & !hwrite & (haddr[7:0] == dp_pkg::OFS_LOS_FLAG);
      hrdata_d     = '0;
      if (take && !hwrite) begin
         unique case (haddr[7:0])
            dp_pkg::OFS_DEINIT_REQ: hrdata_d = {24'h000000, deinit_req_q};
            dp_pkg::OFS_TX_DISABLE: hrdata_d = {24'h000000, tx_dis_q};
            dp_pkg::OFS_TX_SQUELCH: hrdata_d = {24'h000000, squelch_q};
            dp_pkg::OFS_LANE_PATH:  hrdata_d = {8'h00, lane_path_q};
            dp_pkg::OFS_INIT_DUR:   hrdata_d = {28'h0000000, init_dur_q};
            dp_pkg::OFS_STATE_RPT:  hrdata_d = report_q;
            dp_pkg::OFS_CHANGED:    hrdata_d = {24'h000000, changed_q};
            dp_pkg::OFS_LOS_FLAG:   hrdata_d = {24'h000000, los_flag_q};
            dp_pkg::OFS_TX_QUIET:   hrdata_d = {24'h000000, tx_quiet};
            default:                hrdata_d = '0;
         endcase
      end
      deinit_req_d = deinit_req_q;
      tx_dis_d     = tx_dis_q;
      squelch_d    = squelch_q;
      lane_path_d  = lane_path_q;
      init_dur_d   = init_dur_q;
      apply_d      = 8'h00;
      if (wr_pend_q) begin
         unique case (wr_addr_q)
            dp_pkg::OFS_DEINIT_REQ: deinit_req_d = hwdata[7:0];
            dp_pkg::OFS_APPLY_INIT: apply_d      = hwdata[7:0];
            dp_pkg::OFS_TX_DISABLE: tx_dis_d     = hwdata[7:0];
            dp_pkg::OFS_TX_SQUELCH: squelch_d    = hwdata[7:0];
            dp_pkg::OFS_LANE_PATH:  lane_path_d  = hwdata[23:0];
            dp_pkg::OFS_INIT_DUR:   init_dur_d   = hwdata[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q    <= 1'b0;
         wr_addr_q    <= 8'h00;
         hrdata       <= 32'h00000000;
         hreadyout    <= 1'b1;
         hresp        <= 1'b0;
         deinit_req_q <= 8'h00;
         apply_q      <= 8'h00;
         tx_dis_q     <= 8'h00;
         squelch_q    <= 8'h00;
         lane_path_q  <= dp_pkg::RST_LANE_PATH;
         init_dur_q   <= dp_pkg::RST_INIT_DUR;
      end else begin
         wr_pend_q    <= wr_pend_d;
         wr_addr_q    <= wr_addr_d;
         hrdata       <= hrdata_d;
         hreadyout    <= 1'b1;
         hresp        <= 1'b0;
         deinit_req_q <= deinit_req_d;
         apply_q      <= apply_d;
         tx_dis_q     <= tx_dis_d;
         squelch_q    <= squelch_d;
         lane_path_q  <= lane_path_d;
         init_dur_q   <= init_dur_d;
      end
   end

   // Per lane report, pending variable, flags and transmitter control
   always_comb begin
      logic [2:0]        p;
      dp_pkg::dp_state_t s;
      logic              entry;
      logic              exit_met;
      logic [3:0]        pend;
      logic              set;
      p          = 3'h0;
      s          = dp_pkg::S_DEACT;
      entry      = 1'b0;
      exit_met   = 1'b1;
      pend       = 4'h0;
      set        = 1'b0;
      report_d   = report_q;
      pend_d     = pend_q;
      changed_d  = changed_q;
      los_flag_d = los_flag_q;
      power_d    = 8'h00;
      init_d     = 8'h00;
      quiet_d    = 8'hff;
      for (int l = 0; l < L; l++) begin
         p        = path_of(lane_path_q, l);
         s        = st[p];
         entry    = (s != pv[p]);
         pend     = pend_q[4*l +: 4];
         set      = 1'b0;
         exit_met = 1'b1;
         // Same code on every lane of a path, refreshed every cycle
         report_d[4*l +: 4] = dp_pkg::code_of(s);
         if (s == dp_pkg::S_INIT && init_dur_q == 4'h0) begin
            report_d[4*l +: 4] = dp_pkg::CODE_DEACT;
         end
         if (s == dp_pkg::S_DEACT) begin
            exit_met = !cond[p].deinit & !cond[p].reset;
         end else if (s == dp_pkg::S_INITIALIZED) begin
            exit_met = cond[p].redeinit | !cond[p].deactivate;
         end
         if (entry && s == dp_pkg::S_INIT) begin
            pend    = pend | init_dur_q;
            init_d[l]  = 1'b1;
            power_d[l] = !lane_powered_s[l];
         end
         // Chained transitions keep the pending value until a stop
         if (entry && !exit_met) begin
            set  = (pend != 4'h0);
            pend = 4'h0;
         end
         pend_d[4*l +: 4] = pend;
         // Set wins over a read clear in the same cycle
         changed_d[l] = set | (changed_q[l] & !rd_chg);
         los_flag_d[l] = (tx_los_s[l] & (s != dp_pkg::S_DEACT) & (s != dp_pkg::S_INIT))
                         | (los_flag_q[l] & !rd_los);
         if (s == dp_pkg::S_INITIALIZED) begin
            quiet_d[l] = tx_dis_q[l] | squelch_q[l] | tx_los_s[l];
         end else if (s == dp_pkg::S_TXON) begin
            quiet_d[l] = 1'b0;
         end else begin
            quiet_d[l] = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         report_q        <= 32'h11111111;
         pend_q          <= 32'h00000000;
         changed_q       <= 8'h00;
         los_flag_q      <= 8'h00;
         lane_power_up   <= 8'h00;
         lane_init_start <= 8'h00;
         tx_quiet        <= 8'hff;
      end else begin
         report_q        <= report_d;
         pend_q          <= pend_d;
         changed_q       <= changed_d;
         los_flag_q      <= los_flag_d;
         lane_power_up   <= power_d;
         lane_init_start <= init_d;
         tx_quiet        <= quiet_d;
      end
   end
endmodule : dp_ctrl

// [dp_ctrl_assertions.sv]
// Concurrent checks on the pin side of the data path control block
`timescale 1ns/1ps
module dp_ctrl_checker (
   // Clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // Module level conditions
   input wire logic       module_ready_term,
   input wire logic       low_power_condition,
   input wire logic       reset_condition,
   // Lane electronics
   input wire logic [7:0] lane_powered,
   input wire logic [7:0] lane_power_up,
   input wire logic [7:0] lane_init_start,
   input wire logic [7:0] tx_quiet
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Pin inputs pass two sync stages, so every bound below carries that lag
   a_quiet_after_reset: assert property ($rose(hresetn) |-> tx_quiet == 8'hff ##1 tx_quiet == 8'hff)
      else $error("transmitters not quiet after reset");
   a_reset_cond_quiet: assert property (reset_condition [*5] |=> tx_quiet == 8'hff)
      else $error("transmitters not quiet under reset condition");
   a_no_start_reset: assert property (reset_condition [*5] |=> lane_init_start == 8'h00)
      else $error("init started under reset condition");
   a_start_one_cycle: assert property ((lane_init_start & $past(lane_init_start)) == 8'h00)
      else $error("init start longer than one cycle");
   a_power_with_start: assert property ((lane_power_up & ~lane_init_start) == 8'h00)
      else $error("power up outside init entry");
   a_no_power_if_on: assert property ((lane_power_up & $past(lane_powered, 2) & $past(lane_powered, 3)
      & $past(lane_powered, 4) & $past(lane_powered, 5)) == 8'h00)
      else $error("power up of powered lane");
   a_quiet_not_ready: assert property ((!module_ready_term) [*8] |=> tx_quiet == 8'hff)
      else $error("transmitters not quiet while module not ready");
   a_quiet_low_power: assert property (low_power_condition [*8] |=> tx_quiet == 8'hff)
      else $error("transmitters not quiet in low power");

   c_init_start: cover property ($rose(|lane_init_start));
   c_power_up: cover property (lane_power_up != 8'h00);
   c_reset_cond: cover property (reset_condition [*5]);
endmodule : dp_ctrl_checker

bind dp_ctrl dp_ctrl_checker i_dp_ctrl_checker (
   .hclk(hclk), .hresetn(hresetn), .module_ready_term(module_ready_term),
   .low_power_condition(low_power_condition), .reset_condition(reset_condition),
   .lane_powered(lane_powered), .lane_power_up(lane_power_up),
   .lane_init_start(lane_init_start), .tx_quiet(tx_quiet)
);

// [dp_fsm.sv]
// Control state machine of one data path
`timescale 1ns/1ps
module dp_fsm (
   // Clock and reset
   input  wire logic               hclk,
   input  wire logic               hresetn,
   // Path conditions
   input  wire dp_pkg::path_cond_t cond,
   // State now and one cycle ago
   output dp_pkg::dp_state_t       state_q,
   output dp_pkg::dp_state_t       prev_q
);
   dp_pkg::dp_state_t state_d;

   always_comb begin
      state_d = state_q;
      if (cond.reset) begin
         state_d = dp_pkg::S_DEACT;
      end else begin
         unique case (state_q)
            dp_pkg::S_DEACT: begin
               if (!cond.deinit) state_d = dp_pkg::S_INIT;
            end
            dp_pkg::S_INIT: begin
               if (cond.deinit) state_d = dp_pkg::S_DEINIT;
               else if (cond.init_done) state_d = dp_pkg::S_INITIALIZED;
            end
            dp_pkg::S_INITIALIZED: begin
               if (cond.redeinit) state_d = dp_pkg::S_DEINIT;
               else if (!cond.deactivate) state_d = dp_pkg::S_TXON;
            end
            // Deinit work is a single cycle here
            dp_pkg::S_DEINIT: state_d = dp_pkg::S_DEACT;
            // Turn-on exit stays simple until its own logic lands
            dp_pkg::S_TXON: begin
               if (cond.deactivate) state_d = dp_pkg::S_INITIALIZED;
            end
            default: state_d = dp_pkg::S_DEACT;
         endcase
      end
   end

   // Leaving the async reset lands in deactivated
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= dp_pkg::S_DEACT;
         prev_q  <= dp_pkg::S_DEACT;
      end else begin
         state_q <= state_d;
         prev_q  <= state_q;
      end
   end
endmodule : dp_fsm

// [dp_pkg.sv]
// Constants, types and helpers shared by the data path state machine block
// How it works
// - One bus write may request many paths
// - Every lane of a path reports same state
// - Reset, reset exit, deinit end enter deactivated
// - State entry writes report of all path lanes
// - Steady entry without exit sets flag if pending nonzero, clears pending; code does neither on S_TXON entry
// - Transitions never clear flags; host read does
// - No disallowed flag set while deactivated
// - Deactivated and initializing keep transmitters quiescent
// - Leave deactivated only without deinit or reset
// - Init entry ORs pending with init duration
// - Zero init duration hides initializing state report
// - Each init entry starts full lane initialization
// - Lanes configured fully even without input
// - Power up only lanes not yet powered
// - Init: deinit leaves, else done goes initialized
// - Initialized quiescence decided per media lane
// - Initialized: redeinit to deinit, else turn on without deactivate
// - Deinit: not ready, low power, lane request
// - Redeinit adds apply init requests of path
// - Deactivate adds transmitter disable and squelch bits
// - Reset condition jumps straight to deactivated
package dp_pkg;
   localparam int LANES = 8;
   localparam int PATHS = 8;
   localparam int PW    = 3;
   localparam int SW    = 4;
   localparam int DW    = 4;

   localparam logic [7:0] OFS_DEINIT_REQ = 8'h00;
   localparam logic [7:0] OFS_APPLY_INIT = 8'h04;
   localparam logic [7:0] OFS_TX_DISABLE = 8'h08;
   localparam logic [7:0] OFS_TX_SQUELCH = 8'h0c;
   localparam logic [7:0] OFS_LANE_PATH  = 8'h10;
   localparam logic [7:0] OFS_INIT_DUR   = 8'h14;
   localparam logic [7:0] OFS_STATE_RPT  = 8'h18;
   localparam logic [7:0] OFS_CHANGED    = 8'h1c;
   localparam logic [7:0] OFS_LOS_FLAG   = 8'h20;
   localparam logic [7:0] OFS_TX_QUIET   = 8'h24;

   // Lane n belongs to path n after reset
   localparam logic [23:0] RST_LANE_PATH = 24'hfac688;
   localparam logic [3:0]  RST_INIT_DUR  = 4'h1;
   // Start pulse register, lane answer and two sync stages before lane status is fresh
   localparam logic [2:0]  INIT_SETTLE   = 3'h4;

   localparam logic [3:0] CODE_DEACT       = 4'h1;
   localparam logic [3:0] CODE_INIT        = 4'h2;
   localparam logic [3:0] CODE_DEINIT      = 4'h3;
   localparam logic [3:0] CODE_INITIALIZED = 4'h4;
   localparam logic [3:0] CODE_TXON        = 4'h5;

   typedef enum logic [4:0] {
      S_DEACT       = 5'b00001,
      S_INIT        = 5'b00010,
      S_DEINIT      = 5'b00100,
      S_INITIALIZED = 5'b01000,
      S_TXON        = 5'b10000
   } dp_state_t;

   typedef struct packed {
      logic reset;
      logic deinit;
      logic redeinit;
      logic deactivate;
      logic init_done;
   } path_cond_t;

   function automatic logic [3:0] code_of(input dp_state_t s);
      logic [3:0] c;
      c = CODE_DEACT;
      unique case (s)
         S_INIT:        c = CODE_INIT;
         S_DEINIT:      c = CODE_DEINIT;
         S_INITIALIZED: c = CODE_INITIALIZED;
         S_TXON:        c = CODE_TXON;
         default:       c = CODE_DEACT;
      endcase
      return c;
   endfunction : code_of
endpackage : dp_pkg

// [lane_model.sv]
// Lane electronics stand-in that powers up and finishes init on request
`timescale 1ns/1ps
module lane_model (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Requests from the block
   input  wire logic [7:0] lane_power_up,
   input  wire logic [7:0] lane_init_start,
   // Holds every lane not ready, for slow answers
   input  wire logic       hold,
   // Lane status and request counts
   output logic      [7:0] lane_powered,
   output logic      [7:0] lane_ready,
   output int              pu_n,
   output int              ist_n
);
   logic [7:0] done_q;

   // Power stays on once up, so a second init needs no power up
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lane_powered <= 8'h00;
         done_q       <= 8'h00;
         pu_n         <= 0;
         ist_n        <= 0;
      end else begin
         lane_powered <= lane_powered | lane_power_up;
         done_q       <= lane_powered & ~lane_init_start;
         pu_n         <= pu_n + $countones(lane_power_up);
         ist_n        <= ist_n + $countones(lane_init_start);
      end
   end
   assign lane_ready = done_q & {8{!hold}};
endmodule : lane_model

// [sync_2ff.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sync_2ff

// [tb_dp_ctrl.sv]
// Self-checking bench of the data path control block
`timescale 1ns/1ps
module tb_dp_ctrl;
   logic        hclk     = 1'b0;
   logic        hresetn  = 1'b0;
   logic        hsel     = 1'b0;
   logic [31:0] haddr    = 32'h0;
   logic [1:0]  htrans   = 2'h0;
   logic        hwrite   = 1'b0;
   logic [31:0] hwdata   = 32'h0;
   logic        mod_rdy  = 1'b0;
   logic        low_pwr  = 1'b0;
   logic        rst_cond = 1'b0;
   logic [7:0]  tx_los   = 8'h00;
   logic        hold     = 1'b0;
   logic [31:0] hrdata;
   logic        hrdy;
   logic        hresp;
   logic [7:0]  powered, lrdy, pu, ist, quiet;
   int          pu_n, ist_n;
   int          checks = 0;
   int          n_mismatch = 0;

   always #2 hclk = ~hclk;

   dp_ctrl i_dp_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
      .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .module_ready_term(mod_rdy),
      .low_power_condition(low_pwr), .reset_condition(rst_cond), .lane_ready(lrdy),
      .lane_powered(powered), .tx_los(tx_los), .lane_power_up(pu),
      .lane_init_start(ist), .tx_quiet(quiet));

   lane_model i_lane_model (.hclk(hclk), .hresetn(hresetn), .lane_power_up(pu),
      .lane_init_start(ist), .hold(hold), .lane_powered(powered), .lane_ready(lrdy),
      .pu_n(pu_n), .ist_n(ist_n));

   task automatic finish_test;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Waits for hready at a rising edge; a hang ends the run
   task automatic edge_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hrdy !== 1'b1 && n < 100);
      if (n >= 100) begin
         n_mismatch++;
         finish_test();
      end
   endtask : edge_rdy

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      edge_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      chk(r, e);
      chk({31'h0, hresp}, 32'h0);
   endtask : rd

   // Reads until the expected value shows, within a bounded count
   task automatic poll(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         bus(a, 1'b0, 32'h0, r);
         n++;
      end while (r !== e && n < 200);
      chk(r, e);
   endtask : poll

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(dp_pkg::OFS_STATE_RPT, 32'h11111111);
      wr(dp_pkg::OFS_TX_DISABLE, 32'h0);
      rd(dp_pkg::OFS_TX_QUIET, 32'hff);
      // Lanes 0 and 1 share path 0; path 1 is left empty
      wr(dp_pkg::OFS_LANE_PATH, 32'hfac680);
      rd(dp_pkg::OFS_LANE_PATH, 32'hfac680);
      wr(dp_pkg::OFS_TX_DISABLE, 32'hfd);
      wr(dp_pkg::OFS_DEINIT_REQ, 32'hff);
      rd(dp_pkg::OFS_DEINIT_REQ, 32'hff);
      mod_rdy <= 1'b1;
      repeat (10) @(posedge hclk);
      rd(dp_pkg::OFS_STATE_RPT, 32'h11111111);
      wr(dp_pkg::OFS_DEINIT_REQ, 32'h00);
      poll(dp_pkg::OFS_STATE_RPT, 32'h44444444);
      rd(dp_pkg::OFS_CHANGED, 32'hff);
      rd(dp_pkg::OFS_CHANGED, 32'h00);
      chk(pu_n, 8);
      chk(ist_n, 8);
      rd(dp_pkg::OFS_TX_QUIET, 32'hfd);
      tx_los <= 8'h02;
      poll(dp_pkg::OFS_TX_QUIET, 32'hff);
      tx_los <= 8'h00;
      wr(dp_pkg::OFS_APPLY_INIT, 32'h03);
      poll(dp_pkg::OFS_CHANGED, 32'h03);
      chk(ist_n, 10);
      chk(pu_n, 8);
      rd(dp_pkg::OFS_STATE_RPT, 32'h44444444);
      wr(dp_pkg::OFS_TX_DISABLE, 32'hfc);
      poll(dp_pkg::OFS_STATE_RPT, 32'h44444455);
      rd(dp_pkg::OFS_TX_QUIET, 32'hfc);
      wr(dp_pkg::OFS_TX_SQUELCH, 32'h02);
      poll(dp_pkg::OFS_STATE_RPT, 32'h44444444);
      // Lane 1 loss flag has outlived every transition since it was raised
      rd(dp_pkg::OFS_LOS_FLAG, 32'h02);
      rst_cond <= 1'b1;
      poll(dp_pkg::OFS_STATE_RPT, 32'h11111111);
      tx_los <= 8'hff;
      repeat (20) @(posedge hclk);
      rd(dp_pkg::OFS_STATE_RPT, 32'h11111111);
      rd(dp_pkg::OFS_LOS_FLAG, 32'h00);
      rd(dp_pkg::OFS_TX_QUIET, 32'hff);
      tx_los <= 8'h00;
      rst_cond <= 1'b0;
      poll(dp_pkg::OFS_STATE_RPT, 32'h44444444);
      rd(dp_pkg::OFS_CHANGED, 32'hff);
      // Held lanes keep path 0 initializing long enough to watch the report
      hold <= 1'b1;
      wr(dp_pkg::OFS_INIT_DUR, 32'h0);
      wr(dp_pkg::OFS_DEINIT_REQ, 32'h03);
      poll(dp_pkg::OFS_STATE_RPT, 32'h44444411);
      wr(dp_pkg::OFS_DEINIT_REQ, 32'h00);
      for (int i = 0; i < 6; i++) begin
         rd(dp_pkg::OFS_STATE_RPT, 32'h44444411);
      end
      low_pwr <= 1'b1;
      poll(dp_pkg::OFS_STATE_RPT, 32'h11111111);
      wr(dp_pkg::OFS_INIT_DUR, 32'h1);
      low_pwr <= 1'b0;
      poll(dp_pkg::OFS_STATE_RPT, 32'h22222222);
      hold <= 1'b0;
      // Host stays off the bus while the lanes finish initializing
      repeat (12) @(posedge hclk);
      poll(dp_pkg::OFS_STATE_RPT, 32'h44444444);
      rd(dp_pkg::OFS_CHANGED, 32'hff);
      rd(8'h40, 32'h0);
      finish_test();
   end
endmodule : tb_dp_ctrl
